// ==== dv/uart_interrupt_control_props.sv ====
// Bus-side assertions for the serial port interrupt control.
`timescale 1ns/10ps
module uart_interrupt_control_props (
    input wire logic pclk, // Clock.
    input wire logic presetn, // Reset.
    input wire logic psel, // Select.
    input wire logic penable, // Enable.
    input wire logic pwrite, // Write.
    input wire uart_irq_pkg::apb_addr_t paddr, // Address.
    input wire logic [31:0] prdata, // Read data.
    input wire logic pready, // Ready.
    input wire logic pslverr // Error.
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd = pready && !pwrite;
    wire hit = paddr inside {12'h034, 12'h038, 12'h03C, 12'h040};
    property p_rdy; psel && !penable |=> pready && penable; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("long ready");
    property p_ok; pready && hit |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("error on map");
    property p_bad; pready && !hit |-> pslverr && prdata == 0; endproperty
    a_bad: assert property (p_bad) else $error("no error");
    property p_lvl; rd && paddr == 12'h034 |-> prdata[31:6] == 0; endproperty
    a_lvl: assert property (p_lvl) else $error("level bits");
    property p_msk; rd && paddr == 12'h038 |-> (prdata & ~32'h1FF2) == 0; endproperty
    a_msk: assert property (p_msk) else $error("mask bits");
    property p_raw; rd && paddr == 12'h03C |-> (prdata & ~32'h1FF2) == 0; endproperty
    a_raw: assert property (p_raw) else $error("raw bits");
    property p_mis; rd && paddr == 12'h040 |-> (prdata & ~32'h1FF2) == 0; endproperty
    a_mis: assert property (p_mis) else $error("masked bits");
endmodule : uart_interrupt_control_props
bind uart_interrupt_control uart_interrupt_control_props uart_interrupt_control_props_inst (.*);

// ==== dv/uart_interrupt_control_tb.sv ====
// Random and corner-case bench for the serial port interrupt control.
`timescale 1ns/10ps
module uart_interrupt_control_tb;
    import uart_irq_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
    apb_addr_t paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, e, m, s;
    logic [6:0] tx_fill = 0, rx_fill = 0;
    irq_vec_t event_set = 0, event_clear = 0;
    level_code_t c;
    logic er;
    int n_mismatch = 0, checks = 0, cyc = 0;
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            end_sim();
        end
    end
    uart_interrupt_control uart_interrupt_control_inst (.*);
    function automatic int thr(input int k);
        return k > 5 ? 48 : 1 << k;
    endfunction : thr
    task automatic end_sim();
        if (n_mismatch == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    // Back to back: select stays high, the next setup follows each access.
    task automatic xfer(input apb_addr_t a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        penable <= 1'b0;
    endtask : xfer
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("wrong value at %h exp %h got %h", paddr, x, g);
        end
    endtask : chk
    initial begin
        s = $urandom(32'h52BA);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        xfer(12'h034, 1'b0, 32'h0);
        chk(rd, 32'h12);
        xfer(12'h038, 1'b0, 32'h0);
        chk(rd, 32'h0);
        xfer(12'h044, 1'b0, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h1);
        xfer(12'h03C, 1'b1, 32'hFFFF_FFFF);
        chk({31'h0, er}, 32'h0);
        xfer(12'h03C, 1'b0, 32'h0);
        chk(rd & 32'h1FCF, 32'h0);
        chk({31'h0, er}, 32'h0);
        for (int i = 0; i < 24; i++) begin
            c = i[2:0];
            m = $urandom;
            s = $urandom;
            rx_fill <= 7'($urandom_range(64));
            tx_fill <= 7'($urandom_range(64));
            event_set <= s[12:0];
            event_clear <= ~s[12:0];
            xfer(12'h034, 1'b1, {m[31:6], c, c});
            event_set <= '0;
            event_clear <= '0;
            xfer(12'h034, 1'b0, 32'h0);
            chk(rd, {26'h0, c, c});
            xfer(12'h038, 1'b1, m);
            xfer(12'h038, 1'b0, 32'h0);
            chk(rd, m & 32'h1FF2);
            e = s & 32'h1FC2 | 32'(rx_fill >= thr(c)) << 4 | 32'(64 - tx_fill >= thr(c)) << 5;
            xfer(12'h03C, 1'b0, 32'h0);
            chk(rd, e);
            xfer(12'h040, 1'b0, 32'h0);
            chk(rd, e & m);
            chk({31'h0, irq}, {31'h0, |(e & m)});
        end
        psel <= 1'b0;
        @(posedge pclk);
        end_sim();
    end
endmodule : uart_interrupt_control_tb

// ==== inc/uart_irq_cfg.svh ====
// Register offsets, field positions and reset values of the serial port interrupt control.
`ifndef UART_IRQ_CFG_SVH
`define UART_IRQ_CFG_SVH

`define UIC_OFS_LEVEL_SEL 12'h034
`define UIC_OFS_MASK 12'h038
`define UIC_OFS_RAW 12'h03C
`define UIC_OFS_MASKED 12'h040

`define UIC_TX_SEL_LSB 0
`define UIC_TX_SEL_MSB 2
`define UIC_RX_SEL_LSB 3
`define UIC_RX_SEL_MSB 5
`define UIC_LEVEL_SEL_W 6
`define UIC_LEVEL_SEL_RST 6'h12

`define UIC_BIT_CTS 1
`define UIC_BIT_RX 4
`define UIC_BIT_TX 5
`define UIC_BIT_RT 6
`define UIC_BIT_FE 7
`define UIC_BIT_PE 8
`define UIC_BIT_BE 9
`define UIC_BIT_OE 10
`define UIC_BIT_XOFF 11
`define UIC_BIT_TXFE 12

`define UIC_IRQ_W 13
`define UIC_IRQ_IMPL 13'h1FF2
`define UIC_IRQ_STICKY 13'h1FC2
`define UIC_MASK_RST 13'h0000
`define UIC_RAW_RST 13'h0000

`endif

// ==== inc/uart_irq_pkg.sv ====
// Types shared by the serial port interrupt control and its bench.
package uart_irq_pkg;
    typedef logic [11:0] apb_addr_t;
    typedef logic [12:0] irq_vec_t;
    typedef logic [2:0] level_code_t;
endpackage : uart_irq_pkg

// ==== rtl/uart_interrupt_control.sv ====
// Interrupt thresholds, mask and status registers of the serial port, behind an APB slave.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`include "uart_irq_cfg.svh"

module uart_interrupt_control #(
    parameter int FIFO_DEPTH = 64,
    parameter int FILL_W = 7
) (
    input wire logic pclk, // APB clock, 200 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction, high for write.
    input wire uart_irq_pkg::apb_addr_t paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic [FILL_W-1:0] tx_fill, // Words held in the transmit FIFO.
    input wire logic [FILL_W-1:0] rx_fill, // Words held in the receive FIFO.
    input wire uart_irq_pkg::irq_vec_t event_set, // Event pulses from the serial core.
    input wire uart_irq_pkg::irq_vec_t event_clear, // Clear pulses from the clear register.
    output logic irq // Port interrupt, high while an enabled source is pending.
);
    import uart_irq_pkg::*;

    logic [`UIC_LEVEL_SEL_W-1:0] level_sel;
    irq_vec_t mask;
    irq_vec_t raw;

    // Trigger count for a threshold code; codes 6 and 7 both give three quarters.
    function automatic logic [FILL_W-1:0] level_of(input level_code_t code);
        int v;
        case (code)
            3'h0: v = FIFO_DEPTH / 64;
            3'h1: v = FIFO_DEPTH / 32;
            3'h2: v = FIFO_DEPTH / 16;
            3'h3: v = FIFO_DEPTH / 8;
            3'h4: v = FIFO_DEPTH / 4;
            3'h5: v = FIFO_DEPTH / 2;
            default: v = (FIFO_DEPTH * 3) / 4;
        endcase
        if (v < 1) begin
            v = 1;
        end
        return FILL_W'(v);
    endfunction : level_of

    // APB phase and address decode.
    wire setup = psel & ~penable;
    wire wr_done = psel & penable & pready & pwrite;
    wire hit_level = (paddr == `UIC_OFS_LEVEL_SEL);
    wire hit_mask = (paddr == `UIC_OFS_MASK);
    wire hit_raw = (paddr == `UIC_OFS_RAW);
    wire hit_masked = (paddr == `UIC_OFS_MASKED);
    wire mapped = hit_level | hit_mask | hit_raw | hit_masked;

    // Threshold comparison against the selected ladder step.
    wire level_code_t tx_sel = level_sel[`UIC_TX_SEL_MSB:`UIC_TX_SEL_LSB];
    wire level_code_t rx_sel = level_sel[`UIC_RX_SEL_MSB:`UIC_RX_SEL_LSB];
    wire [FILL_W-1:0] tx_space = FILL_W'(FIFO_DEPTH) - tx_fill;
    wire tx_hit = (tx_space >= level_of(tx_sel));
    wire rx_hit = (rx_fill >= level_of(rx_sel));

    // Next register values; an event in the cycle of its clear keeps the bit set.
    wire [`UIC_LEVEL_SEL_W-1:0] next_level_sel =
        (wr_done & hit_level) ? pwdata[`UIC_LEVEL_SEL_W-1:0] : level_sel;
    wire irq_vec_t next_mask =
        (wr_done & hit_mask) ? (pwdata[`UIC_IRQ_W-1:0] & `UIC_IRQ_IMPL) : mask;
    wire irq_vec_t sticky = ((raw & ~event_clear) | event_set) & `UIC_IRQ_STICKY;
    wire irq_vec_t level_bits = irq_vec_t'({rx_hit, 4'h0}) | irq_vec_t'({tx_hit, 5'h00});
    wire irq_vec_t next_raw = sticky | level_bits;
    wire irq_vec_t masked = raw & mask;

    wire [31:0] rd_word =
        hit_level ? {26'h0, level_sel} :
        hit_mask ? {19'h0, mask} :
        hit_raw ? {19'h0, raw} :
        hit_masked ? {19'h0, masked} :
        32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_sel <= `UIC_LEVEL_SEL_RST;
            mask <= `UIC_MASK_RST;
            raw <= `UIC_RAW_RST;
            irq <= 1'b0;
        end else begin
            level_sel <= next_level_sel;
            mask <= next_mask;
            raw <= next_raw;
            irq <= |(next_raw & next_mask);
        end
    end

    // One access cycle: ready rises in the first access phase cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= (setup & ~pwrite) ? rd_word : 32'h0000_0000;
            pready <= setup;
            pslverr <= setup & ~mapped;
        end
    end
endmodule : uart_interrupt_control
